// *** breaker_failure_supervisor.sv ***
// Breaker failure supervisor with APB registers and interrupt
//
// Operation
// R01: Software selects current, position or combined scheme
// R02: Current scheme: fail if current stays high
// R03: Position scheme: fail if never shown open
// R04: Combined: fail only if both still closed
// R05: Frequency deviation drops current; combined acts positional
// R06: Timer keeps running after trigger drops
// R07: Expiry without opening raises backup trip
// R08: Detected opening stops the timer
// R09: Opening with trigger active enters rejected
// R10: Rejected returns to standby once triggers drop
// R11: Lock with backup trip, held until acknowledged
// R12: Three extra inputs always start supervision
// R13: All-trips mode uses every assigned trip
// R14: External mode uses only external trips
// R15: Current mode uses only current trips
// R16: No-assignment mode uses only extra inputs
// R17: Threshold and time from active set
// R18: Supervision time should exceed clearing sum
// R19: Effective trigger ORed, rising edge starts timer
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module breaker_failure_supervisor
  import bfs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trip sources and plant pins
  input wire trip_group_t trips,
  input wire logic [NUM_EXTRA-1:0] extra_trigger,
  input wire plant_t plant,
  input wire logic [15:0] current_level,
  // Outputs
  output logic backup_trip,
  output logic lock,
  output logic [1:0] state,
  output logic current_threshold_active,
  output logic irq
);

  // Input synchronisers
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic [5:0] raw_in;
  logic [5:0] nxt_sync1;
  logic [5:0] nxt_sync2;

  // Registers
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [1:0] set_sel_ff;
  logic [1:0] nxt_set_sel;
  logic [2:0] irq_stat_ff;
  logic [2:0] nxt_irq_stat;
  logic [2:0] irq_en_ff;
  logic [2:0] nxt_irq_en;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;

  // Supervision state
  sup_state_t state_ff;
  sup_state_t nxt_state;
  logic [15:0] ms_ff;
  logic [15:0] nxt_ms;
  logic [15:0] tick_ff;
  logic [15:0] nxt_tick;
  logic trig_d_ff;
  logic nxt_trig_d;
  logic trip_ff;
  logic nxt_trip;
  logic lock_ff;
  logic nxt_lock;

  // Set memory
  logic [31:0] set_word;
  logic set_wr;
  logic [1:0] set_wr_idx;

  // Decoded helpers
  logic apb_access;
  logic apb_wr;
  logic addr_ok;
  logic ack_wr;
  logic irq_clr_wr;
  logic [2:0] events;
  logic s_cur_below;
  logic s_pos_open;
  logic s_freq_dev;
  logic [NUM_EXTRA-1:0] s_extra;
  logic group_trig;
  logic eff_trig;
  logic opened;
  logic tick;
  logic expired;
  scheme_t scheme;
  trig_mode_t trig_mode;

  // Synchronise the extra triggers and plant pins; trips pass unsynchronised
  assign raw_in = {extra_trigger, plant.current_below, plant.position_open,
                   plant.freq_deviates};

  always_comb begin
    nxt_sync1 = raw_in;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  assign s_freq_dev = sync2_ff[0];
  assign s_pos_open = sync2_ff[1];
  assign s_extra = sync2_ff[5:3];

  // Current comparison against active threshold, or pin indication
  assign s_cur_below = sync2_ff[2] |
                       (current_level < set_word[SET_THR_LSB +: 16]); // R17
  assign current_threshold_active = s_cur_below;

  // APB decode
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite;
  assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_SET_SEL) ||
                   (paddr[11:4] == OFS_SET_BASE[11:4]) ||
                   (paddr == OFS_STATUS) || (paddr == OFS_IRQ_STAT) ||
                   (paddr == OFS_IRQ_CLR) || (paddr == OFS_IRQ_EN) ||
                   (paddr == OFS_ACK);
  assign set_wr = apb_wr && (paddr[11:4] == OFS_SET_BASE[11:4]);
  assign set_wr_idx = paddr[3:2];
  assign ack_wr = apb_wr && (paddr == OFS_ACK) && pwdata[0];
  assign irq_clr_wr = apb_wr && (paddr == OFS_IRQ_CLR);
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  // Configuration fields
  assign scheme = scheme_t'(ctrl_ff[CTRL_SCHEME_LSB +: 2]); // R01
  assign trig_mode = trig_mode_t'(ctrl_ff[CTRL_TRIG_LSB +: 2]);

  // Parameter sets, read selected by active set
  bfs_set_mem u_sets (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(set_wr),
    .wr_idx(set_wr_idx),
    .wr_data(pwdata),
    .rd_idx(set_sel_ff),
    .rd_data(set_word)
  );

  // Register file next values
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_set_sel = set_sel_ff;
    nxt_irq_en = irq_en_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (apb_wr && paddr == OFS_CTRL) begin
      nxt_ctrl = {27'h0, pwdata[4:0]};
    end
    if (apb_wr && paddr == OFS_SET_SEL) begin
      nxt_set_sel = pwdata[1:0];
    end
    if (apb_wr && paddr == OFS_IRQ_EN) begin
      nxt_irq_en = pwdata[2:0];
    end
    // Answer latched in the setup cycle so it stands through the access
    if (psel && !penable) begin
      nxt_pslverr = !addr_ok;
      nxt_prdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          OFS_CTRL: nxt_prdata = ctrl_ff;
          OFS_SET_SEL: nxt_prdata = {30'h0, set_sel_ff};
          OFS_STATUS: nxt_prdata = {24'h0, s_cur_below, s_pos_open, s_freq_dev,
                                    lock_ff, trip_ff, eff_trig, state_ff};
          OFS_IRQ_STAT: nxt_prdata = {29'h0, irq_stat_ff};
          OFS_IRQ_EN: nxt_prdata = {29'h0, irq_en_ff};
          default: begin
            if (paddr[11:4] == OFS_SET_BASE[11:4] && paddr[3:2] == set_sel_ff) begin
              nxt_prdata = set_word;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
      set_sel_ff <= 2'h0;
      irq_en_ff <= IRQ_EN_RST;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      set_sel_ff <= nxt_set_sel;
      irq_en_ff <= nxt_irq_en;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Trigger selection
  always_comb begin
    case (trig_mode)
      TRIG_ALL: group_trig = |trips; // R13
      TRIG_EXTERNAL: group_trig = trips.external_trip; // R14
      TRIG_CURRENT: group_trig = trips.current_trip; // R15
      TRIG_NONE: group_trig = 1'b0; // R16
      default: group_trig = 1'b0;
    endcase
  end

  assign eff_trig = ctrl_ff[CTRL_ENABLE_BIT] & (group_trig | (|s_extra)); // R12 R19

  // Opening detection per scheme
  always_comb begin
    case (scheme)
      SCHEME_CURRENT: opened = s_freq_dev ? 1'b0 : s_cur_below; // R02 R05
      SCHEME_POSITION: opened = s_pos_open; // R03
      SCHEME_BOTH: opened = s_freq_dev ? s_pos_open : (s_cur_below | s_pos_open); // R04 R05
      default: opened = s_pos_open;
    endcase
  end

  assign tick = (tick_ff == 16'(TICK_CYCLES - 1));
  assign expired = (ms_ff >= set_word[SET_TIME_LSB +: 16]); // R17

  // Supervision state machine next values
  always_comb begin
    nxt_state = state_ff;
    nxt_ms = ms_ff;
    nxt_tick = tick ? 16'h0000 : tick_ff + 16'h0001;
    nxt_trig_d = eff_trig;
    nxt_trip = 1'b0;
    nxt_lock = lock_ff;
    case (state_ff)
      ST_STANDBY: begin
        nxt_ms = 16'h0000;
        nxt_tick = 16'h0000;
        if (eff_trig && !trig_d_ff) begin
          nxt_state = ST_RUNNING; // R19
        end
      end
      ST_RUNNING: begin
        if (tick) begin
          nxt_ms = ms_ff + 16'h0001; // R06
        end
        if (opened) begin
          nxt_state = eff_trig ? ST_REJECTED : ST_STANDBY; // R08 R09
        end else if (expired) begin
          nxt_state = ST_FAILED;
          nxt_trip = 1'b1; // R07
          nxt_lock = 1'b1; // R11
        end
      end
      ST_REJECTED: begin
        if (!eff_trig) begin
          nxt_state = ST_STANDBY; // R10
        end
      end
      ST_FAILED: begin
        nxt_trip = 1'b1;
        if (!eff_trig || opened) begin
          nxt_state = ST_STANDBY;
          nxt_trip = 1'b0;
        end
      end
      default: nxt_state = ST_STANDBY;
    endcase
    if (ack_wr && !nxt_trip) begin
      nxt_lock = 1'b0; // R11
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_STANDBY;
      ms_ff <= 16'h0000;
      tick_ff <= 16'h0000;
      trig_d_ff <= 1'b0;
      trip_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ms_ff <= nxt_ms;
      tick_ff <= nxt_tick;
      trig_d_ff <= nxt_trig_d;
      trip_ff <= nxt_trip;
      lock_ff <= nxt_lock;
    end
  end

  // Sticky interrupt status, set beats clear
  assign events[IRQ_FAIL_BIT] = (state_ff == ST_RUNNING) && (nxt_state == ST_FAILED);
  assign events[IRQ_REJECT_BIT] = (state_ff == ST_RUNNING) && (nxt_state == ST_REJECTED);
  assign events[IRQ_START_BIT] = (state_ff == ST_STANDBY) && (nxt_state == ST_RUNNING);

  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (irq_clr_wr) begin
      nxt_irq_stat = irq_stat_ff & ~pwdata[2:0];
    end
    nxt_irq_stat = nxt_irq_stat | events;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= 3'h0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // Outputs
  assign irq = |(irq_stat_ff & irq_en_ff);
  assign backup_trip = trip_ff;
  assign lock = lock_ff;
  assign state = state_ff;

endmodule

// *** bfs_pkg.sv ***
// Package for the breaker failure supervisor: map, fields, types
package bfs_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SET_SEL = 12'h004;
  localparam logic [11:0] OFS_SET_BASE = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h030;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h034;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h038;
  localparam logic [11:0] OFS_IRQ_EN = 12'h03c;
  localparam logic [11:0] OFS_ACK = 12'h040;

  // Control field positions
  localparam int CTRL_SCHEME_LSB = 0;
  localparam int CTRL_TRIG_LSB = 2;
  localparam int CTRL_ENABLE_BIT = 4;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SET_RST = 32'h0000_0000;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;

  // Parameter set word: threshold in low half, time in ms in high half
  localparam int SET_THR_LSB = 0;
  localparam int SET_TIME_LSB = 16;
  localparam int NUM_SETS = 4;
  localparam int NUM_EXTRA = 3;

  // Timing: one millisecond tick at 40 MHz
  localparam int CLOCK_HZ = 40_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_US;

  // Interrupt bit positions
  localparam int IRQ_FAIL_BIT = 0;
  localparam int IRQ_REJECT_BIT = 1;
  localparam int IRQ_START_BIT = 2;

  typedef enum logic [1:0] {
    SCHEME_CURRENT = 2'b00,
    SCHEME_POSITION = 2'b01,
    SCHEME_BOTH = 2'b10
  } scheme_t;

  typedef enum logic [1:0] {
    TRIG_ALL = 2'b00,
    TRIG_EXTERNAL = 2'b01,
    TRIG_CURRENT = 2'b10,
    TRIG_NONE = 2'b11
  } trig_mode_t;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_RUNNING = 2'b01,
    ST_REJECTED = 2'b10,
    ST_FAILED = 2'b11
  } sup_state_t;

  // Trip sources assigned to the supervised breaker
  typedef struct packed {
    logic current_trip;
    logic external_trip;
    logic other_trip;
  } trip_group_t;

  // Plant feedback
  typedef struct packed {
    logic current_below;
    logic position_open;
    logic freq_deviates;
  } plant_t;

endpackage

// *** bfs_set_mem.sv ***
// Four-entry parameter set memory with registered read
`timescale 1ns/1ps
module bfs_set_mem
  import bfs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [31:0] wr_data,
  // Read port
  input wire logic [1:0] rd_idx,
  output logic [31:0] rd_data
);

  logic [31:0] mem_ff [NUM_SETS];
  logic [31:0] nxt_mem [NUM_SETS];
  logic [31:0] rd_data_ff;
  logic [31:0] nxt_rd_data;

  // Next value of each entry
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SETS; gi++) begin : g_ent
      always_comb begin
        nxt_mem[gi] = (wr_en && wr_idx == 2'(gi)) ? wr_data : mem_ff[gi];
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          mem_ff[gi] <= SET_RST;
        end else begin
          mem_ff[gi] <= nxt_mem[gi];
        end
      end
    end
  endgenerate

  // Registered read
  always_comb begin
    nxt_rd_data = mem_ff[rd_idx];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= SET_RST;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

endmodule

// *** bfs_props.sv ***
// Port-level timing checks for the supervisor
`timescale 1ns/1ps
module bfs_props
  import bfs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Supervision outputs
  input wire logic backup_trip,
  input wire logic lock,
  input wire logic [1:0] state
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Completed access and lock acknowledge
  wire logic acc = psel && penable;
  wire logic ack = acc && pwrite && paddr == OFS_ACK && pwdata[0];
  a_trip_in_failed: assert property (backup_trip == (state == 2'h3))
    else $error("trip and failed state disagree");
  a_trip_from_run: assert property (
    $rose(backup_trip) |-> $past(state) == 2'h1 && lock)
    else $error("trip not from running or without lock");
  a_lock_held: assert property (lock && !ack |=> lock)
    else $error("lock dropped without acknowledge");
  a_ack_clears: assert property (ack && state != 2'h1 |=> !lock)
    else $error("acknowledge left lock set");
  a_start_standby: assert property (
    state == 2'h1 && !$stable(state) |-> $past(state) == 2'h0)
    else $error("running entered from wrong state");
  a_reject_exit: assert property (
    state == 2'h2 |=> state == 2'h2 || state == 2'h0)
    else $error("rejected left to wrong state");
  a_bad_addr: assert property (acc && paddr > OFS_ACK |-> pslverr)
    else $error("unmapped access not flagged");
  a_rdata_holds: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("read data moved without access");
endmodule

bind breaker_failure_supervisor bfs_props u_props (.clock, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .backup_trip, .lock, .state);

// *** bfs_breaker_model.sv ***
// Breaker model: contacts and primary current
`timescale 1ns/1ps
module bfs_breaker_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bench commands
  input wire logic open_cmd,
  input wire logic slow,
  input wire logic pos_stuck,
  input wire logic cur_stuck,
  input wire logic [15:0] load,
  // Contacts and current
  output logic position_open,
  output logic [15:0] current_level
);
  int cnt_ff;
  logic open_ff;
  // Travel time kept well inside supervision time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 0;
      open_ff <= 1'b0;
    end else if (open_cmd == open_ff) begin
      cnt_ff <= 0;
    end else if (cnt_ff < (slow ? 40 : 4)) begin
      cnt_ff <= cnt_ff + 1;
    end else begin
      open_ff <= open_cmd;
    end
  end
  // A stuck contact or pole keeps its closed reading
  assign position_open = open_ff && !pos_stuck;
  assign current_level = open_ff && !cur_stuck ? 16'h0000 : load;
endmodule

// *** tb_breaker_failure_supervisor.sv ***
// Self-checking bench for the breaker failure supervisor
`timescale 1ns/1ps
module tb_breaker_failure_supervisor
  import bfs_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, backup_trip, lock, cta, irq, pos_o, hit;
  logic [1:0] state;
  trip_group_t trips = '0;
  logic [2:0] extra = 3'h0;
  logic freq = 1'b0, open_cmd = 1'b0, slow = 1'b0, pstk = 1'b0, cstk = 1'b0;
  logic [15:0] thr, load = 16'hffff, cur;
  plant_t plant_w;
  logic [31:0] exp_q[$], msk_q[$];
  int miscompares = 0, total_checks = 0, seed = 40339;

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // Current pin low; current judged by level
  assign plant_w = {1'b0, pos_o, freq};
  breaker_failure_supervisor u_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .trips, .extra_trigger(extra), .plant(plant_w),
    .current_level(cur), .backup_trip, .lock, .state, .current_threshold_active(cta), .irq);
  bfs_breaker_model u_brk (.clock, .rst_n, .open_cmd, .slow, .pos_stuck(pstk),
    .cur_stuck(cstk), .load, .position_open(pos_o), .current_level(cur));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bus transfer; a read notes its expected data
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m);
    int n;
    n = 0;
    if (!wr) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Scoreboard: response taken at the edge that completes the access
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      chk(pslverr, paddr > OFS_ACK);
      if (!pwrite) begin
        chk(prdata & msk_q.pop_front(), exp_q.pop_front());
      end
    end
  end

  task automatic cfg(input logic [1:0] sch, input logic [1:0] md, input logic [15:0] t);
    apb(1, OFS_SET_BASE, {t, thr}, 0);
    apb(1, OFS_CTRL, {27'h0, 1'b1, md, sch}, 0);
  endtask

  task automatic go(input logic [2:0] tg, input logic [2:0] ex);
    trips <= tg;
    extra <= ex;
    repeat (60) @(posedge clock);
  endtask

  task automatic see(input logic [1:0] s, input logic t);
    apb(0, OFS_STATUS, {27'h0, t, t, 1'b0, s}, 32'h1b);
  endtask

  task automatic drop();
    go(3'h0, 3'h0);
    apb(1, OFS_ACK, 32'h1, 0);
    see(2'h0, 1'b0);
  endtask

  // Main sequence
  initial begin
    thr = 16'($random(seed)) & 16'h7fff | 16'h0100;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(0, OFS_CTRL, CTRL_RST, '1);
    apb(0, OFS_IRQ_EN, 32'h0, '1);
    see(2'h0, 1'b0);
    apb(0, 12'h0fc, 32'h0, '1);
    // Trigger modes against each source, breaker closed, instant expiry
    for (int m = 0; m < 4; m++) begin
      cfg(SCHEME_POSITION, m[1:0], 16'h0);
      for (int k = 0; k < 4; k++) begin
        hit = k == 3 || m == 0 || m + k == 2;
        go(k < 3 ? 3'h4 >> k : 3'h0, k == 3 ? 3'h1 << (m % 3) : 3'h0);
        see(hit ? 2'h3 : 2'h0, hit);
        drop();
      end
    end
    // Opening seen by each scheme while still triggered
    for (int s = 0; s < 3; s++) begin
      cfg(2'(s), TRIG_NONE, 16'hffff);
      pstk <= s == 0;
      cstk <= s != 0;
      slow <= s == 1;
      open_cmd <= 1'b1;
      go(3'h0, 3'h2);
      see(2'h2, 1'b0);
      open_cmd <= 1'b0;
      go(3'h0, 3'h0);
      see(2'h0, 1'b0);
    end
    // Off-nominal frequency hides the current drop
    freq <= 1'b1;
    pstk <= 1'b1;
    cstk <= 1'b0;
    open_cmd <= 1'b1;
    cfg(SCHEME_BOTH, TRIG_NONE, 16'hffff);
    go(3'h0, 3'h4);
    see(2'h1, 1'b0);
    freq <= 1'b0;
    go(3'h0, 3'h4);
    see(2'h2, 1'b0);
    open_cmd <= 1'b0;
    go(3'h0, 3'h0);
    cfg(SCHEME_CURRENT, TRIG_NONE, 16'h0001);
    freq <= 1'b1;
    open_cmd <= 1'b1;
    go(3'h0, 3'h1);
    go(3'h0, 3'h0);
    see(2'h1, 1'b0);
    go(3'h0, 3'h1);
    for (int i = 0; i < 42000 && state !== 2'h3; i++) @(posedge clock);
    if (state !== 2'h3) begin
      miscompares++;
      wrap_up();
    end
    see(2'h3, 1'b1);
    // Interrupt masked, enabled, cleared
    chk(irq, 1'b0);
    apb(1, OFS_IRQ_EN, 32'h1, 0);
    chk(irq, 1'b1);
    apb(1, OFS_IRQ_CLR, 32'h1, 0);
    apb(0, OFS_IRQ_STAT, 32'h0, 32'h1);
    chk(irq, 1'b0);
    open_cmd <= 1'b0;
    freq <= 1'b0;
    drop();
    // Second set: own threshold and zero time
    apb(1, OFS_SET_BASE + 12'h4, {16'h0, thr + 16'h0080}, 0);
    apb(1, OFS_SET_SEL, 32'h1, 0);
    apb(0, OFS_SET_BASE + 12'h4, {16'h0, thr + 16'h0080}, '1);
    load <= thr + 16'h007f;
    go(3'h0, 3'h0);
    chk(cta, 1'b1);
    load <= thr + 16'h0080;
    go(3'h0, 3'h0);
    chk(cta, 1'b0);
    load <= 16'hffff;
    apb(1, OFS_CTRL, 32'h11, 0);
    go(3'h0, 3'h1);
    see(2'h3, 1'b1);
    drop();
    wrap_up();
  end
endmodule
